// [hdl/mask_matcher.sv]
`timescale 1ns/10ps
`default_nettype none

module mask_matcher (
  mask_if.matcher mi
);
  logic [63:0] hit;
  logic [63:0] shifted;

  // ----------------------------------------------------------------
  // per-bit compare of the low-order uid bits under the mask
  // ----------------------------------------------------------------
  for (genvar i = 0; i < 64; i++) begin : g_bit
    assign hit[i] = (8'(i) >= mi.mask_len) || (mi.uid[i] == mi.mask_val[i]);
  end

  assign mi.match = &hit;
  // slot is taken from the uid bits just above the mask
  assign shifted = mi.uid >> mi.mask_len;
  assign mi.slot_no = shifted[3:0];

endmodule // mask_matcher

`default_nettype wire

// [hdl/rf_initiate_inventory_fastread_cmds.sv]
// What this block does
// - inventory-after-initiate silent unless latch set
// - subcarrier bit set on fast command: error
// - inventory request: flags, C1h/D1h, filter, mask
// - inventory flag required, anticollision sequence runs
// - fast commands answer at double rate
// - id response: flags, format id, uid
// - faulty inventory request gets no response
// - busy mode: pin low until response end
// - write-progress mode: pin stays released
// - busy low for initiate and block read
// - quick initiate sets latch, answers when ready
// - quick initiate non-addressed only, else silent
// - quick initiate: flags, C2h, maker, CRC
// - latch cleared only by power loss
// - block read: flags, C3h, uid, first, count
// - max 32 blocks, one sector, else error
// - per block: optional status byte, 32 bits
// - status: bit0 lock, top three zero
// - read errors 03h, 10h, 15h
`timescale 1ns/10ps
`default_nettype none

module rf_initiate_inventory_fastread_cmds
  import rf_init_pkg::*;
#(
  parameter logic [7:0] MFG_CODE = 8'h5A // arbitrary value
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic req_sof,
  input wire logic req_byte_valid,
  input wire logic [7:0] req_byte,
  input wire logic req_eof,
  input wire logic req_crc_ok,
  input wire logic slot_marker,
  input wire logic tag_ready,
  input wire logic [63:0] uid,
  output logic resp_valid,
  output logic [7:0] resp_data,
  output logic resp_last,
  output logic resp_fast,
  input wire logic resp_ready,
  input wire logic resp_done,
  output logic blk_rd,
  output logic [6:0] blk_addr,
  input wire logic [31:0] blk_data,
  input wire logic blk_rd_prot,
  input wire logic [4:0] sec_status,
  input wire logic rf_field,
  input wire logic rf_activity_pin_i,
  output logic rf_activity_pin_o,
  output logic rf_activity_pin_oe
);

  typedef struct packed {
    st_t st;
    rk_t kind;
    logic latch;
    logic busy;
    logic [7:0] flags;
    logic [7:0] cmd;
    logic mfg_ok;
    logic family_ok;
    logic uid_ok;
    logic [4:0] idx;
    logic [7:0] mask_len;
    logic [63:0] mask_val;
    logic [7:0] first;
    logic [7:0] count;
    logic [3:0] slot;
    logic [7:0] err;
    logic [3:0] pos;
    logic hdr;
    logic [2:0] ub;
    logic [6:0] blk;
    logic [4:0] left;
    logic [31:0] word;
    logic [7:0] secst;
    logic resp_valid;
    logic [7:0] resp_data;
    logic resp_last;
    logic resp_fast;
    logic blk_rd;
    logic act_o;
    logic act_oe;
    logic [7:0] ctrl;
    logic [7:0] fmt_id;
    logic [7:0] family;
    logic [7:0] rdata;
    logic [2:0] sync;
    logic field_ok;
  } state_t;

  state_t s_q;
  state_t s_d;
  mask_if mif ();

  mask_matcher u_match (
    .mi(mif)
  );

  // ----------------------------------------------------------------
  // request decode helpers
  // ----------------------------------------------------------------
  logic cmd_inv;
  logic cmd_init;
  logic cmd_read;
  logic fast;
  logic sub;
  logic slots16;
  logic [4:0] body;
  logic [4:0] mpos;
  logic [4:0] mpos_m1;
  logic [4:0] upos;
  logic [8:0] exp_inv;
  logic [8:0] last_blk;
  logic mask_ok;
  logic len_ok;
  logic common_ok;
  logic [2:0] unit;
  logic [2:0] ub_m1;
  logic [3:0] pos_m2;
  logic [7:0] rd_byte;

  assign cmd_inv = (s_q.cmd == CMD_INV) || (s_q.cmd == CMD_FAST_INV);
  assign cmd_init = (s_q.cmd == CMD_INIT) || (s_q.cmd == CMD_FAST_INIT);
  assign cmd_read = (s_q.cmd == CMD_FAST_RDM);
  assign fast = is_fast(s_q.cmd);
  assign sub = s_q.flags[FLG_SUBCAR];
  assign slots16 = !s_q.flags[FLG_NBSLOT];
  assign body = s_q.idx - IDX_BODY;
  assign mpos = body - {4'h0, s_q.flags[FLG_FAMILY]};
  assign mpos_m1 = mpos - 5'h01;
  assign upos = s_q.flags[FLG_ADDR] ? UID_BYTES : 5'h00;
  assign exp_inv = 9'(IDX_BODY) + 9'h001 + {8'h00, s_q.flags[FLG_FAMILY]} +
                   (({1'b0, s_q.mask_len} + 9'h007) >> 3);
  assign mask_ok = s_q.mask_len <= (slots16 ? MASK_MAX_16SLOT : MASK_MAX_1SLOT);
  assign last_blk = {1'b0, s_q.first} + {1'b0, s_q.count};
  assign unit = s_q.flags[FLG_OPTION] ? UNIT_STATUS : UNIT_PLAIN;
  assign ub_m1 = s_q.ub - 3'h1;
  assign pos_m2 = s_q.pos - 4'h2;

  always_comb begin
    len_ok = 1'b0;
    if (cmd_inv) begin
      len_ok = ({4'h0, s_q.idx} == exp_inv) && mask_ok;
    end else if (cmd_init) begin
      len_ok = (s_q.idx == IDX_BODY);
    end else if (cmd_read) begin
      len_ok = (s_q.idx == IDX_BODY + upos + 5'h02);
    end
  end

  assign common_ok = req_crc_ok && s_q.mfg_ok && len_ok;

  // status byte first when asked for, then data low byte first
  always_comb begin
    if (s_q.flags[FLG_OPTION]) begin
      rd_byte = (s_q.ub == 3'h0) ? s_q.secst : s_q.word[{ub_m1[1:0], 3'b000} +: 8];
    end else begin
      rd_byte = s_q.word[{s_q.ub[1:0], 3'b000} +: 8];
    end
  end

  assign mif.mask_len = s_q.mask_len;
  assign mif.mask_val = s_q.mask_val;
  assign mif.uid = uid;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.rdata = 8'h00;
    s_d.blk_rd = 1'b0;
    // field detect: three stages, a change counts once the last two agree
    s_d.sync = {s_q.sync[1:0], rf_field};
    if (s_q.sync[2] == s_q.sync[1]) begin
      s_d.field_ok = s_q.sync[2];
    end
    if (reg_wr) begin
      unique case (reg_addr)
        REG_CTRL: s_d.ctrl = reg_wdata;
        REG_FMT: s_d.fmt_id = reg_wdata;
        REG_FAMILY: s_d.family = reg_wdata;
        default: ;
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        REG_CTRL: s_d.rdata = s_q.ctrl;
        REG_STATUS: s_d.rdata = {5'h00, s_q.field_ok, s_q.busy, s_q.latch};
        REG_FMT: s_d.rdata = s_q.fmt_id;
        REG_FAMILY: s_d.rdata = s_q.family;
        default: s_d.rdata = 8'h00;
      endcase
    end
    if (req_sof) begin
      // a new frame also aborts a pending slot wait or response
      s_d.st = ST_RX;
      s_d.busy = 1'b1;
      s_d.idx = IDX_FLAGS;
      s_d.mfg_ok = 1'b0;
      s_d.family_ok = 1'b1;
      s_d.uid_ok = 1'b1;
      s_d.mask_len = 8'h00;
      s_d.mask_val = 64'h0000_0000_0000_0000;
      s_d.first = 8'h00;
      s_d.count = 8'h00;
      s_d.resp_valid = 1'b0;
      s_d.resp_last = 1'b0;
    end else begin
      unique case (s_q.st)
        ST_IDLE: ;
        ST_RX: begin
          if (req_byte_valid) begin
            if (s_q.idx != IDX_SAT) begin
              s_d.idx = s_q.idx + 5'h01;
            end
            if (s_q.idx == IDX_FLAGS) begin
              s_d.flags = req_byte;
            end else if (s_q.idx == IDX_CMD) begin
              s_d.cmd = req_byte;
              if (!is_ours(req_byte)) begin
                // another command handler owns the pin from here
                s_d.st = ST_IDLE;
                s_d.busy = 1'b0;
              end
            end else if (s_q.idx == IDX_MFG) begin
              s_d.mfg_ok = (req_byte == MFG_CODE);
            end else if (cmd_inv) begin
              if (s_q.flags[FLG_FAMILY] && body == 5'h00) begin
                s_d.family_ok = (req_byte == 8'h00) || (req_byte == s_q.family);
              end else if (mpos == 5'h00) begin
                s_d.mask_len = req_byte;
              end else if (mpos <= UID_BYTES) begin
                s_d.mask_val[{mpos_m1[2:0], 3'b000} +: 8] = req_byte;
              end
            end else if (cmd_read) begin
              if (body < upos) begin
                s_d.uid_ok = s_q.uid_ok && (req_byte == uid[{body[2:0], 3'b000} +: 8]);
              end else if (body == upos) begin
                s_d.first = req_byte;
              end else if (body == upos + 5'h01) begin
                s_d.count = req_byte;
              end
            end
          end else if (req_eof) begin
            // silence is the default outcome of any faulty request
            s_d.st = ST_IDLE;
            s_d.busy = 1'b0;
            s_d.kind = RK_ERR;
            s_d.pos = 4'h0;
            if (cmd_inv) begin
              if (common_ok && s_q.latch && s_q.flags[FLG_INVENT]) begin
                if (fast && sub) begin
                  s_d.st = ST_SEND;
                  s_d.busy = 1'b1;
                  s_d.err = ERR_GENERIC;
                end else if (s_q.family_ok && mif.match) begin
                  s_d.busy = 1'b1;
                  s_d.kind = RK_ID;
                  s_d.slot = 4'h0;
                  s_d.st = (slots16 && mif.slot_no != 4'h0) ? ST_SLOT : ST_SEND;
                end
              end
            end else if (cmd_init) begin
              if (common_ok && !s_q.flags[FLG_INVENT] && !s_q.flags[FLG_SELECT] &&
                  !s_q.flags[FLG_ADDR]) begin
                if (fast && sub) begin
                  s_d.err = ERR_GENERIC;
                end else begin
                  s_d.latch = 1'b1;
                  s_d.kind = RK_ID;
                end
                if (tag_ready) begin
                  s_d.st = ST_SEND;
                  s_d.busy = 1'b1;
                end
              end
            end else if (cmd_read && common_ok && s_q.uid_ok) begin
              s_d.st = ST_SEND;
              s_d.busy = 1'b1;
              if (sub) begin
                s_d.err = ERR_GENERIC;
              end else if (s_q.flags[FLG_INVENT]) begin
                s_d.err = ERR_OPTION;
              end else if (last_blk >= NUM_BLOCKS ||
                           s_q.first[7:SECTOR_LSB] != last_blk[7:SECTOR_LSB]) begin
                s_d.err = ERR_BLOCK;
              end else begin
                s_d.kind = RK_READ;
                s_d.st = ST_FETCH;
                s_d.blk_rd = 1'b1;
                s_d.blk = s_q.first[6:0];
                s_d.left = s_q.count[4:0];
                s_d.hdr = 1'b0;
              end
            end
          end
        end
        ST_SLOT: begin
          // in busy mode the pin stays low while the slot is missing; only a new frame or power loss ends it
          if (slot_marker) begin
            s_d.slot = s_q.slot + 4'h1;
            if (s_d.slot == mif.slot_no) begin
              s_d.st = ST_SEND;
            end
          end
        end
        ST_FETCH: s_d.st = ST_GRAB;
        ST_GRAB: begin
          s_d.word = blk_data;
          s_d.secst = {3'b000, sec_status};
          s_d.st = ST_SEND;
          s_d.ub = 3'h0;
          if (!s_q.hdr && blk_rd_prot) begin
            s_d.kind = RK_ERR;
            s_d.err = ERR_RDPROT;
            s_d.pos = 4'h0;
          end
        end
        ST_SEND: begin
          if (!s_q.resp_valid || resp_ready) begin
            if (s_q.resp_valid && s_q.resp_last) begin
              s_d.resp_valid = 1'b0;
              s_d.resp_last = 1'b0;
              s_d.st = ST_END;
            end else begin
              s_d.resp_valid = 1'b1;
              s_d.resp_fast = fast;
              s_d.resp_last = 1'b0;
              s_d.pos = s_q.pos + 4'h1;
              unique case (s_q.kind)
                RK_ID: begin
                  if (s_q.pos == 4'h0) begin
                    s_d.resp_data = RSP_FLAGS_OK;
                  end else if (s_q.pos == 4'h1) begin
                    s_d.resp_data = s_q.fmt_id;
                  end else begin
                    s_d.resp_data = uid[{pos_m2[2:0], 3'b000} +: 8];
                  end
                  s_d.resp_last = (s_q.pos == ID_LAST_POS);
                end
                RK_ERR: begin
                  s_d.resp_data = (s_q.pos == 4'h0) ? RSP_FLAGS_ERR : s_q.err;
                  s_d.resp_last = (s_q.pos == ERR_LAST_POS);
                end
                RK_READ: begin
                  if (!s_q.hdr) begin
                    s_d.resp_data = RSP_FLAGS_OK;
                    s_d.hdr = 1'b1;
                  end else if (s_q.ub == unit) begin
                    s_d.resp_valid = 1'b0;
                    s_d.st = ST_FETCH;
                    s_d.blk_rd = 1'b1;
                    s_d.blk = s_q.blk + 7'h01;
                    s_d.left = s_q.left - 5'h01;
                  end else begin
                    s_d.resp_data = rd_byte;
                    s_d.ub = s_q.ub + 3'h1;
                    s_d.resp_last = (s_q.ub == unit - 3'h1) && (s_q.left == 5'h00);
                  end
                end
                default: ;
              endcase
            end
          end
        end
        ST_END: begin
          if (resp_done) begin
            s_d.st = ST_IDLE;
            s_d.busy = 1'b0;
          end
        end
      endcase
    end
    if (!s_d.field_ok) begin
      s_d.st = ST_IDLE;
      s_d.latch = 1'b0;
      s_d.busy = 1'b0;
      s_d.resp_valid = 1'b0;
      s_d.resp_last = 1'b0;
      s_d.blk_rd = 1'b0;
    end
    // the pin is only ever pulled low, never driven high
    s_d.act_oe = s_d.ctrl[CTRL_BUSY_BIT] && s_d.busy;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_q <= '0;
      s_q.ctrl <= CTRL_RESET;
      s_q.fmt_id <= FMT_RESET;
      s_q.family <= FAMILY_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign resp_valid = s_q.resp_valid;
  assign resp_data = s_q.resp_data;
  assign resp_last = s_q.resp_last;
  assign resp_fast = s_q.resp_fast;
  assign blk_rd = s_q.blk_rd;
  assign blk_addr = s_q.blk;
  assign rf_activity_pin_o = s_q.act_o;
  assign rf_activity_pin_oe = s_q.act_oe;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  logic eof_here;
  assign eof_here = (s_q.st == ST_RX) && req_eof && !req_sof;

  a_no_latch_silent: assert property (
    eof_here && cmd_inv && !s_q.latch |=> !resp_valid [*3])
    else $error("inventory answered without initiate latch");

  a_subcar_error: assert property (
    eof_here && cmd_read && common_ok && s_q.uid_ok && sub && s_q.field_ok && s_d.field_ok
    |=> ##1 (resp_valid && resp_data == RSP_FLAGS_ERR))
    else $error("subcarrier flag did not give an error response");

  a_fast_rate: assert property (
    resp_valid |-> (resp_fast == is_fast(s_q.cmd)))
    else $error("response rate does not follow the command");

  a_id_length: assert property (
    resp_valid && resp_last && s_q.kind == RK_ID |-> s_q.pos == ID_LAST_POS + 4'h1)
    else $error("id response is not ten bytes");

  a_busy_slot: assert property (
    s_q.st == ST_SLOT && s_q.ctrl[CTRL_BUSY_BIT] |=> (rf_activity_pin_oe || !s_q.field_ok))
    else $error("pin released while waiting for slot");

  a_wip_hiz: assert property (
    !s_q.ctrl[CTRL_BUSY_BIT] |-> !rf_activity_pin_oe && !rf_activity_pin_o)
    else $error("pin driven in write-progress mode");

  a_init_latch: assert property (
    eof_here && cmd_init && common_ok && !(fast && sub) && !s_q.flags[FLG_INVENT] &&
    !s_q.flags[FLG_SELECT] && !s_q.flags[FLG_ADDR] && s_d.field_ok |=> s_q.latch)
    else $error("initiate did not set the latch");

  a_power_clear: assert property (
    $fell(s_q.field_ok) |-> !s_q.latch && !rf_activity_pin_oe)
    else $error("latch or pin survived power loss");

  a_sector_cross: assert property (
    eof_here && cmd_read && common_ok && s_q.uid_ok && !sub && !s_q.flags[FLG_INVENT] &&
    s_q.first[7:SECTOR_LSB] != last_blk[7:SECTOR_LSB] && s_d.field_ok
    |=> ##1 (resp_valid && resp_data == RSP_FLAGS_ERR) ##[1:20]
    (resp_valid && resp_data == ERR_BLOCK))
    else $error("sector crossing not refused");

  a_status_byte: assert property (
    resp_valid && s_q.kind == RK_READ && s_q.flags[FLG_OPTION] && s_q.ub == 3'h1
    |-> resp_data[7:5] == 3'b000 && resp_data[0] == s_q.secst[0])
    else $error("status byte reserved bits not zero");

  c_inv_answer: cover property (s_q.st == ST_SLOT ##[1:100] (resp_valid && s_q.kind == RK_ID));
  c_read_done: cover property (resp_valid && resp_last && s_q.kind == RK_READ);
  c_init_ok: cover property (eof_here && cmd_init ##1 s_q.latch);

endmodule // rf_initiate_inventory_fastread_cmds

`default_nettype wire

// [include/mask_if.sv]
`timescale 1ns/10ps
`default_nettype none

interface mask_if;
  logic [7:0] mask_len;
  logic [63:0] mask_val;
  logic [63:0] uid;
  logic match;
  logic [3:0] slot_no;
  modport matcher (input mask_len, input mask_val, input uid, output match, output slot_no);
  modport requester (output mask_len, output mask_val, output uid, input match, input slot_no);
endinterface

`default_nettype wire

// [include/rf_init_pkg.sv]
package rf_init_pkg;

  // ----------------------------------------------------------------
  // command codes and request layout
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_FAST_INV = 8'hC1;
  localparam logic [7:0] CMD_INV = 8'hD1;
  localparam logic [7:0] CMD_FAST_INIT = 8'hC2;
  localparam logic [7:0] CMD_INIT = 8'hD2;
  localparam logic [7:0] CMD_FAST_RDM = 8'hC3;
  localparam logic [4:0] IDX_FLAGS = 5'h00;
  localparam logic [4:0] IDX_CMD = 5'h01;
  localparam logic [4:0] IDX_MFG = 5'h02;
  localparam logic [4:0] IDX_BODY = 5'h03;
  localparam logic [4:0] IDX_SAT = 5'h1F;
  localparam logic [4:0] UID_BYTES = 5'h08;
  localparam int FLG_SUBCAR = 0;
  localparam int FLG_INVENT = 2;
  localparam int FLG_SELECT = 4;
  localparam int FLG_ADDR = 5;
  localparam int FLG_FAMILY = 4;
  localparam int FLG_NBSLOT = 5;
  localparam int FLG_OPTION = 6;
  localparam logic [7:0] MASK_MAX_1SLOT = 8'h40;
  localparam logic [7:0] MASK_MAX_16SLOT = 8'h3C;

  // ----------------------------------------------------------------
  // responses and memory
  // ----------------------------------------------------------------
  localparam logic [7:0] RSP_FLAGS_OK = 8'h00;
  localparam logic [7:0] RSP_FLAGS_ERR = 8'h01;
  localparam logic [7:0] ERR_OPTION = 8'h03;
  localparam logic [7:0] ERR_GENERIC = 8'h0F;
  localparam logic [7:0] ERR_BLOCK = 8'h10;
  localparam logic [7:0] ERR_RDPROT = 8'h15;
  localparam logic [3:0] ID_LAST_POS = 4'h9;
  localparam logic [3:0] ERR_LAST_POS = 4'h1;
  localparam logic [8:0] NUM_BLOCKS = 9'h080;
  localparam int SECTOR_LSB = 5;
  localparam logic [2:0] UNIT_PLAIN = 3'h4;
  localparam logic [2:0] UNIT_STATUS = 3'h5;

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_FMT = 4'h2;
  localparam logic [3:0] REG_FAMILY = 4'h3;
  localparam int CTRL_BUSY_BIT = 0;
  localparam logic [7:0] CTRL_RESET = 8'h01;
  localparam logic [7:0] FMT_RESET = 8'h00;
  localparam logic [7:0] FAMILY_RESET = 8'h00;

  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_SLOT, ST_FETCH, ST_GRAB, ST_SEND, ST_END} st_t;
  typedef enum logic [1:0] {RK_ID, RK_ERR, RK_READ} rk_t;

  function automatic logic is_fast(input logic [7:0] c);
    is_fast = (c == CMD_FAST_INV) || (c == CMD_FAST_INIT) || (c == CMD_FAST_RDM);
  endfunction

  function automatic logic is_ours(input logic [7:0] c);
    is_ours = is_fast(c) || (c == CMD_INV) || (c == CMD_INIT);
  endfunction

endpackage

// [tb/rf_reader_model.sv]
`timescale 1ns/10ps
`default_nettype none
module rf_reader_model (
  input wire logic sys_clk,
  input wire logic resp_valid,
  input wire logic resp_last,
  output logic resp_ready,
  output logic resp_done,
  input wire logic blk_rd,
  input wire logic [6:0] blk_addr,
  output logic [31:0] blk_data
);
  logic [1:0] n_q;
  logic [2:0] d_q;
  logic rd_q;
  logic [7:0] b_q;
  initial begin
    n_q = 2'h0;
    d_q = 3'h0;
    rd_q = 1'b0;
    b_q = 8'h00;
    resp_ready = 1'b0;
    resp_done = 1'b0;
  end
  // stalls one cycle in four, so the sender must hold its byte
  always @(posedge sys_clk) begin
    n_q <= n_q + 2'h1;
    rd_q <= blk_rd;
    b_q <= {blk_addr, 1'b1};
    resp_ready <= (n_q != 2'h0);
    resp_done <= (d_q == 3'h1);
    if (resp_valid && resp_ready && resp_last)
      d_q <= 3'h4;
    else if (d_q != 3'h0)
      d_q <= d_q - 3'h1;
  end
  // data stand only in the cycle after the read strobe, one distinct value per byte
  assign blk_data = rd_q ? {b_q ^ 8'h30, b_q ^ 8'h20, b_q ^ 8'h10, b_q} : {8{n_q, n_q}};
endmodule // rf_reader_model
`default_nettype wire

// [tb/tb_rf_initiate_inventory_fastread_cmds.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_rf_initiate_inventory_fastread_cmds;
  import rf_init_pkg::*;
  localparam logic [7:0] MFG = 8'h5A; // arbitrary maker value
  logic sys_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, req_sof = 1'b0;
  logic req_byte_valid = 1'b0, req_eof = 1'b0, req_crc_ok = 1'b0, slot_marker = 1'b0;
  logic tag_ready = 1'b1, blk_rd_prot = 1'b0, rf_field = 1'b1, rd_d = 1'b0;
  logic fast_e = 1'b1, busy_m = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, req_byte = 8'h00, reg_rdata, resp_data;
  logic [4:0] sec_status = 5'h1F;
  logic [63:0] uid;
  logic resp_valid, resp_last, resp_fast, resp_ready, resp_done, blk_rd;
  logic rf_activity_pin_o, rf_activity_pin_oe;
  logic [6:0] blk_addr;
  logic [31:0] blk_data;
  logic [7:0] rq[$], bq[$];
  integer seed = 32'h3073, errors = 0, samples_checked = 0;

  always #5 sys_clk = ~sys_clk;

  rf_initiate_inventory_fastread_cmds #(.MFG_CODE(MFG)) u_dut (
    .sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .req_sof, .req_byte_valid, .req_byte, .req_eof, .req_crc_ok, .slot_marker,
    .tag_ready, .uid, .resp_valid, .resp_data, .resp_last, .resp_fast,
    .resp_ready, .resp_done, .blk_rd, .blk_addr, .blk_data, .blk_rd_prot,
    .sec_status, .rf_field, .rf_activity_pin_i(~rf_activity_pin_oe),
    .rf_activity_pin_o, .rf_activity_pin_oe
  );
  rf_reader_model u_rdr (
    .sys_clk, .resp_valid, .resp_last, .resp_ready, .resp_done, .blk_rd,
    .blk_addr, .blk_data
  );

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    samples_checked++;
    if (s !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic give_verdict;
    if (errors == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // a byte with nothing queued is compared against X, so it always fails
  always @(posedge sys_clk) begin
    rd_d <= reg_rd;
    if (rd_d)
      chk("reg_rdata", rq.pop_front(), reg_rdata);
    if (resp_valid === 1'b1 && resp_ready) begin
      chk("resp_data", bq.size() ? bq.pop_front() : 8'hXX, resp_data);
      chk("resp_fast", fast_e, resp_fast);
    end
  end

  task automatic rg(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    if (!w)
      rq.push_back(d);
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
  endtask

  task automatic frame(input logic [7:0] b[$], input logic crc);
    @(posedge sys_clk);
    req_sof <= 1'b1;
    @(posedge sys_clk);
    req_sof <= 1'b0;
    foreach (b[i]) begin
      req_byte_valid <= 1'b1;
      req_byte <= b[i];
      @(posedge sys_clk);
    end
    chk("pin_oe", busy_m, rf_activity_pin_oe);
    req_byte_valid <= 1'b0;
    req_eof <= 1'b1;
    req_crc_ok <= crc;
    @(posedge sys_clk);
    req_eof <= 1'b0;
  endtask

  task automatic drain;
    for (int i = 0; i < 400 && bq.size() != 0; i++)
      @(posedge sys_clk);
    repeat (8) @(posedge sys_clk);
  endtask

  task automatic exp2(input logic [7:0] a, input logic [7:0] b);
    bq.push_back(a);
    bq.push_back(b);
  endtask

  task automatic exp_id;
    exp2(RSP_FLAGS_OK, 8'hA5);
    for (int i = 0; i < 8; i++)
      bq.push_back(uid[8*i+:8]);
  endtask

  initial begin
    uid = {$random(seed), $random(seed)};
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (8) @(posedge sys_clk);
    rg(0, REG_CTRL, CTRL_RESET);
    rg(0, 4'hF, 8'h00);
    rg(0, REG_STATUS, 8'h04);
    rg(1, REG_FMT, 8'hA5);
    rg(0, REG_FMT, 8'hA5);
    frame('{8'h24, CMD_FAST_INV, MFG, 8'h00}, 1);
    drain;
    frame('{8'h10, CMD_FAST_INIT, MFG}, 1);
    drain;
    exp2(RSP_FLAGS_ERR, ERR_GENERIC);
    frame('{8'h01, CMD_FAST_INIT, MFG}, 1);
    drain;
    rg(0, REG_STATUS, 8'h04);
    tag_ready <= 1'b0;
    frame('{8'h00, CMD_FAST_INIT, MFG}, 1);
    drain;
    rg(0, REG_STATUS, 8'h05);
    tag_ready <= 1'b1;
    exp_id;
    frame('{8'h00, CMD_FAST_INIT, MFG}, 1);
    drain;
    chk("pin_oe", 8'h00, rf_activity_pin_oe);
    rg(0, REG_STATUS, 8'h05);
    frame('{8'h20, CMD_FAST_INV, MFG, 8'h00}, 1);
    frame('{8'h24, CMD_FAST_INV, MFG, 8'h00}, 0);
    frame('{8'h24, CMD_FAST_INV, MFG, 8'h04, {4'h0, ~uid[3:0]}}, 1);
    drain;
    exp_id;
    frame('{8'h24, CMD_FAST_INV, MFG, 8'h04, {4'h0, uid[3:0]}}, 1);
    drain;
    rg(1, REG_FAMILY, 8'h3C);
    frame('{8'h34, CMD_FAST_INV, MFG, 8'h3D, 8'h00}, 1);
    exp_id;
    frame('{8'h34, CMD_FAST_INV, MFG, 8'h3C, 8'h00}, 1);
    drain;
    fast_e = 1'b0;
    exp_id;
    frame('{8'h04, CMD_INV, MFG, 8'h00}, 1);
    repeat (uid[3:0]) begin
      repeat (3) @(posedge sys_clk);
      slot_marker <= 1'b1;
      @(posedge sys_clk);
      slot_marker <= 1'b0;
    end
    drain;
    fast_e = 1'b1;
    bq.push_back(RSP_FLAGS_OK);
    for (int a = 30; a < 32; a++) begin
      bq.push_back({3'h0, sec_status});
      for (int j = 0; j < 4; j++)
        bq.push_back({a[6:0], 1'b1} ^ 8'(16 * j));
    end
    frame('{8'h40, CMD_FAST_RDM, MFG, 8'h1E, 8'h01}, 1);
    drain;
    for (int k = 0; k < 4; k++) begin
      blk_rd_prot <= (k == 2);
      exp2(RSP_FLAGS_ERR, k == 0 ? ERR_BLOCK : k == 1 ? ERR_OPTION :
           k == 2 ? ERR_RDPROT : ERR_GENERIC);
      frame('{k == 1 ? 8'h44 : k == 3 ? 8'h01 : 8'h00, CMD_FAST_RDM, MFG, 8'h1E,
              k == 0 ? 8'h02 : 8'h00}, 1);
      drain;
    end
    blk_rd_prot <= 1'b0;
    rg(1, REG_CTRL, 8'h00);
    busy_m = 1'b0;
    fast_e = 1'b0;
    exp_id;
    frame('{8'h00, CMD_INIT, MFG}, 1);
    drain;
    rf_field <= 1'b0;
    repeat (10) @(posedge sys_clk);
    rf_field <= 1'b1;
    repeat (8) @(posedge sys_clk);
    rg(0, REG_STATUS, 8'h04);
    frame('{8'h24, CMD_FAST_INV, MFG, 8'h00}, 1);
    drain;
    chk("bytes_left", 8'h00, 8'(bq.size()));
    give_verdict;
  end

  // the whole sequence needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    give_verdict;
  end
endmodule // tb_rf_initiate_inventory_fastread_cmds
`default_nettype wire
